// ### design/sflc_defs.svh
`ifndef SFLC_DEFS_SVH
`define SFLC_DEFS_SVH

// serial word layout
`define SFLC_WORD_W      21
`define SFLC_CTL_R       2'h0
`define SFLC_CTL_N       2'h1
`define SFLC_CTL_FUNC    2'h2
`define SFLC_CTL_INIT    2'h3

// function latch fields
`define SFLC_F_CLR       2
`define SFLC_F_PD_ARM    3
`define SFLC_F_MUX_LO    4
`define SFLC_F_MUX_HI    6
`define SFLC_F_POL       7
`define SFLC_F_TRI       8
`define SFLC_F_FL_EN     9
`define SFLC_F_FL_MODE   11
`define SFLC_F_TO_LO     11
`define SFLC_F_TO_HI     14
`define SFLC_F_PD_SYNC   19

// reference latch and feedback latch fields
`define SFLC_R_LO        2
`define SFLC_R_HI        15
`define SFLC_N_LO        2
`define SFLC_N_HI        19
`define SFLC_N_BOOST     20

// reset values
`define SFLC_FUNC_RST    21'h000000
`define SFLC_R_RST       14'h0001
`define SFLC_N_RST       18'h00001

// timing counts
`define SFLC_TO_UNIT     7'h04
`define SFLC_LD_WIN      4'h3
`define SFLC_LD_COUNT    3'h5

`endif

// ### design/sflc_pkg.sv
package sflc_pkg;

	typedef struct packed {
		logic sclk;
		logic sdata;
		logic le;
		logic refin;
		logic rfin;
	} sflc_pins_t;

	typedef struct packed {
		sflc_pins_t  s1;
		sflc_pins_t  s2;
		sflc_pins_t  prev;
		logic [20:0] shreg;
		logic [20:0] func;
		logic [13:0] r_val;
		logic [17:0] n_val;
		logic        boost;
		logic [13:0] r_cnt;
		logic [17:0] n_cnt;
		logic [6:0]  to_cnt;
		logic        pd_prog;
		logic        up;
		logic        dn;
		logic [3:0]  err_w;
		logic [2:0]  ld_cnt;
		logic        lock;
		logic        o_up;
		logic        o_dn;
		logic        o_oe_n;
		logic        o_high;
		logic        o_loop;
		logic        o_mon;
		logic        o_pd;
	} sflc_state_t;

endpackage

// ### design/sflc_top.sv
`timescale 1ns/10ps
`default_nettype none
`include "sflc_defs.svh"

module sflc_top
	import sflc_pkg::*;
(
	input  wire logic i_ref_clk,
	input  wire logic i_reset,
	input  wire logic i_ser_clk,
	input  wire logic i_ser_data,
	input  wire logic i_ser_le,
	input  wire logic i_chip_en,
	input  wire logic i_ref_in,
	input  wire logic i_rf_in,
	output var  logic o_pump_up,
	output var  logic o_pump_dn,
	output var  logic o_pump_oe_n,
	output var  logic o_pump_high,
	output var  logic o_loop_switch_out,
	output var  logic o_monitor_out,
	output var  logic o_powered_down
);

	sflc_state_t q;
	sflc_state_t d;
	// chip enable synchroniser
	logic [1:0]  ce_s;
	logic        ce_clr;
	logic        ce_ok;
	logic        sclk_rise;
	logic        le_rise;
	logic        ref_edge;
	logic        rf_edge;
	logic        ref_pulse;
	logic        fb_pulse;
	logic        pump_event;
	logic        pd;
	logic        hold;
	logic        fl_en;
	logic        fl_active;
	logic        nxt_up;
	logic        nxt_dn;
	logic [13:0] r_load;
	logic [17:0] n_load;
	logic [6:0]  to_limit;

	// timeout period in reference divider periods
	function automatic logic [6:0] to_period(input logic [3:0] sel);
		logic [6:0] t;
		t = {3'h0, sel} + 7'h01;
		return 7'((t * `SFLC_TO_UNIT));
	endfunction

	// monitor multiplexer selection
	function automatic logic mon_pick(
		input logic [2:0] sel,
		input logic       lock,
		input logic       rpul,
		input logic       npul,
		input logic       sdo,
		input logic       pdn
	);
		logic r;
		r = 1'b0;
		unique case (sel)
			3'h0: r = 1'b0;
			3'h1: r = lock;
			3'h2: r = npul;
			3'h3: r = sdo;
			3'h4: r = rpul;
			3'h5: r = lock;
			3'h6: r = pdn;
			3'h7: r = 1'b1;
		endcase
		return r;
	endfunction

	// chip enable low clears at once, release passes two flops
	assign ce_clr = i_reset | ~i_chip_en;
	assign ce_ok  = ce_s[1];

	always_ff @(posedge i_ref_clk or posedge ce_clr)
	begin
		if (ce_clr)
			ce_s <= 2'h0;
		else
			ce_s <= {ce_s[0], 1'b1};
	end

	always_comb
	begin
		d = q;
		// pins enter through two flops, a third feeds edge detect
		d.s1.sclk  = i_ser_clk;
		d.s1.sdata = i_ser_data;
		d.s1.le    = i_ser_le;
		d.s1.refin = i_ref_in;
		d.s1.rfin  = i_rf_in;
		d.s2   = q.s1;
		d.prev = q.s2;

		sclk_rise = q.s2.sclk & ~q.prev.sclk;
		le_rise   = q.s2.le & ~q.prev.le;
		ref_edge  = q.s2.refin & ~q.prev.refin;
		rf_edge   = q.s2.rfin & ~q.prev.rfin;

		// a zero ratio is taken as one
		r_load = (q.r_val == 14'h0000) ? 14'h0001 : q.r_val;
		n_load = (q.n_val == 18'h00000) ? 18'h00001 : q.n_val;

		// power-down state
		pd   = ~ce_ok | q.pd_prog;
		hold = pd | q.func[`SFLC_F_CLR];

		// reference divider
		ref_pulse = 1'b0;
		if (hold)
		begin
			d.r_cnt = r_load;
		end
		else if (ref_edge)
		begin
			if (q.r_cnt <= 14'h0001)
			begin
				d.r_cnt   = r_load;
				ref_pulse = 1'b1;
			end
			else
			begin
				d.r_cnt = q.r_cnt - 14'h0001;
			end
		end

		// feedback divider
		fb_pulse = 1'b0;
		if (hold)
		begin
			d.n_cnt = n_load;
		end
		else if (rf_edge)
		begin
			if (q.n_cnt <= 18'h00001)
			begin
				d.n_cnt  = n_load;
				fb_pulse = 1'b1;
			end
			else
			begin
				d.n_cnt = q.n_cnt - 18'h00001;
			end
		end

		pump_event = ref_pulse | fb_pulse;

		// programmed power-down
		// sync mode waits for a pump event, so no frequency jump
		if (!q.func[`SFLC_F_PD_ARM])
		begin
			d.pd_prog = 1'b0;
		end
		else if (!q.func[`SFLC_F_PD_SYNC])
		begin
			d.pd_prog = 1'b1;
		end
		else if (pump_event)
		begin
			d.pd_prog = 1'b1;
		end

		// phase detector
		// both requests set together cancel each other
		nxt_up = q.up | ref_pulse;
		nxt_dn = q.dn | fb_pulse;
		if (hold || (nxt_up && nxt_dn))
		begin
			d.up = 1'b0;
			d.dn = 1'b0;
		end
		else
		begin
			d.up = nxt_up;
			d.dn = nxt_dn;
		end

		// lock detect: short phase error for several periods
		// error width saturates, so a long error never wraps
		if (q.up || q.dn)
		begin
			if (q.err_w != 4'hf)
				d.err_w = q.err_w + 4'h1;
		end
		if (pd)
		begin
			d.ld_cnt = 3'h0;
			d.lock   = 1'b0;
			d.err_w  = 4'h0;
		end
		else if (ref_pulse)
		begin
			d.err_w = 4'h0;
			if (q.err_w < `SFLC_LD_WIN)
			begin
				if (q.ld_cnt != `SFLC_LD_COUNT)
					d.ld_cnt = q.ld_cnt + 3'h1;
			end
			else
			begin
				d.ld_cnt = 3'h0;
			end
			d.lock = (d.ld_cnt == `SFLC_LD_COUNT);
		end

		// fastlock
		fl_en     = q.func[`SFLC_F_FL_EN];
		fl_active = fl_en & q.boost;
		// timer length follows the four-bit field
		to_limit  = to_period(q.func[`SFLC_F_TO_HI:`SFLC_F_TO_LO]);
		if (pd || !(fl_active && q.func[`SFLC_F_FL_MODE]))
		begin
			d.to_cnt = 7'h00;
		end
		else if (ref_pulse)
		begin
			if (q.to_cnt >= to_limit - 7'h01)
			begin
				d.to_cnt = 7'h00;
				// a host write below still wins over expiry
				d.boost  = 1'b0;
			end
			else
			begin
				d.to_cnt = q.to_cnt + 7'h01;
			end
		end

		// serial input, live in every power state
		if (sclk_rise)
			d.shreg = {q.shreg[19:0], q.s2.sdata};
		if (le_rise)
		begin
			unique case (q.shreg[1:0])
				`SFLC_CTL_FUNC:
					d.func = q.shreg;
				`SFLC_CTL_R:
					d.r_val = q.shreg[`SFLC_R_HI:`SFLC_R_LO];
				`SFLC_CTL_N:
				begin
					d.n_val = q.shreg[`SFLC_N_HI:`SFLC_N_LO];
					d.boost = q.shreg[`SFLC_N_BOOST];
				end
				// init words refused, the latch keeps its value
				`SFLC_CTL_INIT:
					d.func = q.func;
			endcase
		end

		// registered outputs, pump requests silenced while held
		if (hold)
		begin
			d.o_up = 1'b0;
			d.o_dn = 1'b0;
		end
		else if (q.func[`SFLC_F_POL])
		begin
			d.o_up = q.up;
			d.o_dn = q.dn;
		end
		else
		begin
			d.o_up = q.dn;
			d.o_dn = q.up;
		end
		// counter clear three-states the pump as well
		d.o_oe_n = hold | q.func[`SFLC_F_TRI];
		d.o_high = fl_active;
		// with fastlock enabled, loop switch low only during active fastlock; with it off, loop switch follows the mode bit
		if (fl_en)
			d.o_loop = ~fl_active;
		else
			d.o_loop = q.func[`SFLC_F_FL_MODE];
		// monitor sees the live pulses of this cycle
		d.o_mon = mon_pick(q.func[`SFLC_F_MUX_HI:`SFLC_F_MUX_LO],
			q.lock, ref_pulse, fb_pulse, q.shreg[20], pd);
		d.o_pd = pd;
	end

	always_ff @(posedge i_ref_clk or posedge i_reset)
	begin
		if (i_reset)
		begin
			// powered down and pump three-stated in reset
			q         <= '0;
			q.func    <= `SFLC_FUNC_RST;
			q.r_val   <= `SFLC_R_RST;
			q.n_val   <= `SFLC_N_RST;
			q.r_cnt   <= `SFLC_R_RST;
			q.n_cnt   <= `SFLC_N_RST;
			q.o_oe_n  <= 1'b1;
			q.o_pd    <= 1'b1;
		end
		else
		begin
			q <= d;
		end
	end

	// outputs come straight from the state flops
	assign o_pump_up         = q.o_up;
	assign o_pump_dn         = q.o_dn;
	assign o_pump_oe_n       = q.o_oe_n;
	assign o_pump_high       = q.o_high;
	assign o_loop_switch_out = q.o_loop;
	assign o_monitor_out     = q.o_mon;
	assign o_powered_down    = q.o_pd;

endmodule

`default_nettype wire

// ### testbench/sflc_top_assertions.sv
`timescale 1ns/10ps
`default_nettype none
module sflc_checker
(
	input wire logic i_ref_clk,
	input wire logic i_reset,
	input wire logic i_chip_en,
	input wire logic o_pump_up,
	input wire logic o_pump_dn,
	input wire logic o_pump_oe_n,
	input wire logic o_pump_high,
	input wire logic o_loop_switch_out,
	input wire logic o_powered_down
);
	default clocking @(posedge i_ref_clk);
	endclocking
	default disable iff (i_reset);
	sequence ce_off;
		!i_chip_en [*2];
	endsequence
	sequence pd_left;
		$fell(o_powered_down);
	endsequence
	pd_tri_a: assert property (o_powered_down |-> o_pump_oe_n)
		else $error("pump driven in power-down");
	pd_quiet_a: assert property (o_powered_down |-> !o_pump_up && !o_pump_dn)
		else $error("pump request in power-down");
	ce_drop_a: assert property (!i_chip_en |-> ##[1:3] o_powered_down)
		else $error("chip enable low without power-down");
	ce_hold_a: assert property (ce_off |=> o_powered_down && o_pump_oe_n)
		else $error("power-down lost with chip enable low");
	pd_stay_a: assert property (o_powered_down && !i_chip_en |=> o_powered_down)
		else $error("power-down left with chip enable low");
	ce_sync_a: assert property (pd_left |-> $past(i_chip_en) && $past(i_chip_en, 2))
		else $error("power-down left without synchronised enable");
	pd_load_a: assert property (pd_left |-> !o_pump_up && !o_pump_dn)
		else $error("pump request on leaving power-down");
	boost_loop_a: assert property (o_pump_high |-> !o_loop_switch_out)
		else $error("loop switch high during fastlock");
endmodule
bind sflc_top sflc_checker chk (.i_ref_clk(i_ref_clk), .i_reset(i_reset),
	.i_chip_en(i_chip_en), .o_pump_up(o_pump_up), .o_pump_dn(o_pump_dn),
	.o_pump_oe_n(o_pump_oe_n), .o_pump_high(o_pump_high),
	.o_loop_switch_out(o_loop_switch_out), .o_powered_down(o_powered_down));
`default_nettype wire

// ### testbench/sflc_host.sv
`timescale 1ns/10ps
`default_nettype none
module sflc_host
#(
	parameter realtime HALF = 62.5
)
(
	output var logic o_sclk,
	output var logic o_data,
	output var logic o_le
);
	initial
	begin
		o_sclk = 0;
		o_data = 0;
		o_le = 0;
	end
	// msb first; control code rides in the two last bits
	task automatic send(input logic [20:0] w);
		for (int i = 20; i >= 0; i--)
		begin
			o_data = w[i];
			#HALF o_sclk = 1;
			#HALF o_sclk = 0;
		end
		// released data line shows the inverse, not a held value
		o_data = ~w[0];
		#HALF o_le = 1;
		#HALF o_le = 0;
	endtask
endmodule
`default_nettype wire

// ### testbench/test_sflc_top.sv
`timescale 1ns/10ps
`default_nettype none
module test_sflc_top;
	logic        clk = 0, rst = 1, ce = 1, rin = 0, fin = 0;
	wire logic   sclk, sdat, le, up, dn, oen, hi, lp, mon, pdn;
	int          failures = 0, n_tests = 0;
	logic [31:0] rs = 32'h8e02;
	logic [4:0]  q[$];
	event        look;
	logic        still = 1'b0;
	// ctl 11 words other than 10b are bench actions: 3 ce low, 7 ce high, b long wait,
	// f pins frozen, 13 pins free again
	logic [20:0] wd[19] = '{21'h000872, 21'h00010b, 21'h100032,
		21'h00006a, 21'h00000a, 21'h000102, 21'h000006,
		21'h000062, 21'h000003, 21'h000007, 21'h000202,
		21'h100005, 21'h000005, 21'h007a02, 21'h100005,
		21'h00000b, 21'h00000f, 21'h08006a, 21'h000013};
	// expected {powered_down, oe_n, high, loop, monitor}
	logic [4:0]  ex[19] = '{5'h03, 5'h03, 5'h01, 5'h19, 5'h18, 5'h08,
		5'h08, 5'h00, 5'h19, 5'h00, 5'h02, 5'h04, 5'h02, 5'h02, 5'h04,
		5'h02, 5'h02, 5'h00, 5'h19};
	always #5 clk = ~clk;
	sflc_host host (.o_sclk(sclk), .o_data(sdat), .o_le(le));
	sflc_top dut (.i_ref_clk(clk), .i_reset(rst), .i_ser_clk(sclk),
		.i_ser_data(sdat), .i_ser_le(le), .i_chip_en(ce), .i_ref_in(rin),
		.i_rf_in(fin), .o_pump_up(up), .o_pump_dn(dn), .o_pump_oe_n(oen),
		.o_pump_high(hi), .o_loop_switch_out(lp), .o_monitor_out(mon),
		.o_powered_down(pdn));
	function automatic logic [31:0] xorshift(input logic [31:0] s);
		logic [31:0] x;
		x = s ^ (s << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction
	always @(posedge clk)
	begin
		rs = xorshift(rs);
		rin <= #1 rs[0] & ~still;
		fin <= #1 rs[9] & ~still;
	end
	task automatic close_out();
		if (failures == 0 && n_tests > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	always @(look)
	begin
		n_tests++;
		if ({pdn, oen, hi, lp, mon} !== q[0])
		begin
			failures++;
			$display("ERROR %0t: got %b want %b", $time,
				{pdn, oen, hi, lp, mon}, q[0]);
		end
		void'(q.pop_front());
	end
	initial
	begin
		#200000;
		failures++;
		close_out();
	end
	initial
	begin
		repeat (4) @(posedge clk);
		#1 rst = 0;
		foreach (wd[i])
		begin
			@(posedge clk);
			#1;
			case (wd[i])
				21'h000003: ce = 1'b0;
				21'h000007: ce = 1'b1;
				21'h00000b: repeat (1000) @(posedge clk);
				21'h00000f: still = 1'b1;
				21'h000013: still = 1'b0;
				default: host.send(wd[i]);
			endcase
			repeat (40) @(posedge clk);
			q.push_back(ex[i]);
			#2 ->look;
		end
		#10 close_out();
	end
endmodule
`default_nettype wire
